// >>> pold_pkg.sv
// shared constants and types for the port output and led drive block
package pold_pkg;

  localparam int NUM_PORTS  = 5;
  localparam int PORT_WIDTH = 8;
  localparam int IDX_WIDTH  = 12;
  localparam int LED_PORT   = 2;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LED_SINK_ENABLE     = 12'hf82;
  localparam logic [11:0] IDX_LED_LEVEL_MSB       = 12'hf83;
  localparam logic [11:0] IDX_LED_LEVEL_LSB       = 12'hf84;
  localparam logic [11:0] IDX_PORT_A_OUTPUT_VALUE = 12'hfd3;
  localparam logic [11:0] IDX_PORT_B_OUTPUT_VALUE = 12'hfd7;
  localparam logic [11:0] IDX_PORT_C_OUTPUT_VALUE = 12'hfdb;
  localparam logic [11:0] IDX_PORT_D_OUTPUT_VALUE = 12'hfdf;
  localparam logic [11:0] IDX_PORT_E_OUTPUT_VALUE = 12'hfe3;
  localparam logic [4:0][11:0] IDX_PORT_OUTPUT_VALUE = {
    IDX_PORT_E_OUTPUT_VALUE, IDX_PORT_D_OUTPUT_VALUE,
    IDX_PORT_C_OUTPUT_VALUE, IDX_PORT_B_OUTPUT_VALUE,
    IDX_PORT_A_OUTPUT_VALUE};

  // index field position inside haddr
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 13;

  localparam logic [7:0]  RESET_VALUE = 8'h00;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam logic [1:0]  HRESP_OKAY  = 2'h0;

  // current level codes: msb from the high register
  typedef enum logic [1:0] {
    LED_3MA  = 2'h0,
    LED_7MA  = 2'h1,
    LED_13MA = 2'h2,
    LED_20MA = 2'h3
  } pold_led_level_type;

  // one bus access held through its data phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] index;
  } pold_access_type;

  // gating from the neighbouring port configuration logic
  typedef struct packed {
    logic [7:0] isOutput;
    logic [7:0] altFunc;
    logic [7:0] openDrain;
  } pold_pin_cfg_type;

endpackage

// >>> pold_ahb_if.sv
// ahb-lite address phase capture for the register file
`timescale 1ns/100ps
module pold_ahb_if (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic                     hready,
  output pold_pkg::pold_access_type     addrPhase,
  output pold_pkg::pold_access_type     dataPhase
);

  logic addrTaken;
  logic wordAligned;

  // nonseq or seq, word sized, aligned; anything else is ignored
  assign wordAligned = (haddr[1:0] == 2'h0) &&
                       (hsize == pold_pkg::HSIZE_WORD);
  assign addrTaken   = hsel && hready && htrans[1] && wordAligned;

  assign addrPhase.valid = addrTaken;
  assign addrPhase.write = hwrite;
  assign addrPhase.index =
    haddr[pold_pkg::ADDR_IDX_MSB:pold_pkg::ADDR_IDX_LSB];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dataPhase <= '0;
    end else if (hready) begin
      dataPhase <= addrPhase;
    end
  end

endmodule

// >>> pold_pin_drive.sv
// per pin output gating for one 8-bit port
`timescale 1ns/100ps
module pold_pin_drive (
  input  pold_pkg::pold_pin_cfg_type cfg,
  input  wire logic [7:0]            outValue,
  output logic [7:0]                 pinOut,
  output logic [7:0]                 pinOutEn_n
);

  genvar b;
  generate
    for (b = 0; b < pold_pkg::PORT_WIDTH; b++) begin : g_bit
      logic driveAllowed;
      logic driveHigh;
      assign driveAllowed = cfg.isOutput[b] && !cfg.altFunc[b];  // [RULE_01]
      assign driveHigh    = outValue[b] && !cfg.openDrain[b];    // [RULE_03]
      assign pinOut[b]    = outValue[b];                         // [RULE_02]
      assign pinOutEn_n[b] =
        !(driveAllowed && (!outValue[b] || driveHigh));          // [RULE_01]
    end
  endgenerate

endmodule

// >>> pold_top.sv
// port output data registers and led current sink control
//
// Summary of operation
// RULE_01 - pin follows its data bit only as output and not alternate function
// RULE_02 - a driven pin shows low for stored zero, high for stored one
// RULE_03 - with open drain set, a stored one releases the pin instead
// RULE_04 - five 8-bit read/write output registers, ports A to E, reset zero
// RULE_05 - 8-bit sink enable register, reset zero; one connects the sink
// RULE_06 - sink acts only when led alternate function is selected
// RULE_07 - two 8-bit level registers, high and low bit, reset zero
// RULE_08 - code {high,low}: 00 3mA, 01 7mA, 10 13mA, 11 20mA
// RULE_09 - every led pin has its own enable and level
// RULE_10 - outputs change on the edge after a write; reads return stored value
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module pold_top (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [2:0]                    hburst,
  input  wire logic [3:0]                    hprot,
  input  wire logic                          hmastlock,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic [1:0]                         hresp,
  input  pold_pkg::pold_pin_cfg_type [4:0]   pinCfg,
  input  wire logic [7:0]                    ledFuncSelect,
  output logic [4:0][7:0]                    pinOut,
  output logic [4:0][7:0]                    pinOutEn_n,
  output logic [7:0]                         ledSinkOn,
  output logic [7:0][1:0]                    ledCurrentCode
);

  pold_pkg::pold_access_type addrPhase;
  pold_pkg::pold_access_type dataPhase;

  logic [4:0][7:0] portOutputValue;
  logic [7:0]      ledSinkEnable;
  logic [7:0]      ledLevelMsb;
  logic [7:0]      ledLevelLsb;

  logic            dataWrite;
  logic [4:0]      portWriteHit;
  logic            sinkWriteHit;
  logic            msbWriteHit;
  logic            lsbWriteHit;
  logic [4:0]      portReadHit;
  logic            sinkReadHit;
  logic            msbReadHit;
  logic            lsbReadHit;
  logic [4:0][7:0] portReadOr;
  logic [7:0]      storedByte;
  logic            writeBypass;
  logic [7:0]      readByte;
  logic [31:0]     next_hrdata;

  pold_ahb_if u_ahb_if (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .addrPhase (addrPhase),
    .dataPhase (dataPhase)
  );

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = pold_pkg::HRESP_OKAY;

  // write decode in the data phase
  assign dataWrite    = dataPhase.valid && dataPhase.write;
  assign sinkWriteHit = dataWrite &&
    (dataPhase.index == pold_pkg::IDX_LED_SINK_ENABLE);
  assign msbWriteHit  = dataWrite &&
    (dataPhase.index == pold_pkg::IDX_LED_LEVEL_MSB);
  assign lsbWriteHit  = dataWrite &&
    (dataPhase.index == pold_pkg::IDX_LED_LEVEL_LSB);

  // read decode in the address phase
  assign sinkReadHit =
    (addrPhase.index == pold_pkg::IDX_LED_SINK_ENABLE);
  assign msbReadHit  = (addrPhase.index == pold_pkg::IDX_LED_LEVEL_MSB);
  assign lsbReadHit  = (addrPhase.index == pold_pkg::IDX_LED_LEVEL_LSB);

  genvar p;
  generate
    for (p = 0; p < pold_pkg::NUM_PORTS; p++) begin : g_port
      assign portWriteHit[p] = dataWrite &&
        (dataPhase.index == pold_pkg::IDX_PORT_OUTPUT_VALUE[p]);
      assign portReadHit[p] =
        (addrPhase.index == pold_pkg::IDX_PORT_OUTPUT_VALUE[p]);

      // output value registers, one per port
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          portOutputValue[p] <= pold_pkg::RESET_VALUE;       // [RULE_04]
        end else if (portWriteHit[p]) begin
          portOutputValue[p] <= hwdata[7:0];                 // [RULE_04]
        end
      end

      if (p == 0) begin : g_first
        assign portReadOr[p] = {8{portReadHit[p]}} & portOutputValue[p];
      end else begin : g_rest
        assign portReadOr[p] = portReadOr[p-1] |
          ({8{portReadHit[p]}} & portOutputValue[p]);
      end

      pold_pin_drive u_pin_drive (
        .cfg        (pinCfg[p]),
        .outValue   (portOutputValue[p]),
        .pinOut     (pinOut[p]),
        .pinOutEn_n (pinOutEn_n[p])
      );
    end
  endgenerate

  // led enable and level registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ledSinkEnable <= pold_pkg::RESET_VALUE;                // [RULE_05]
    end else if (sinkWriteHit) begin
      ledSinkEnable <= hwdata[7:0];                          // [RULE_05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ledLevelMsb <= pold_pkg::RESET_VALUE;                  // [RULE_07]
    end else if (msbWriteHit) begin
      ledLevelMsb <= hwdata[7:0];                            // [RULE_07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ledLevelLsb <= pold_pkg::RESET_VALUE;                  // [RULE_07]
    end else if (lsbWriteHit) begin
      ledLevelLsb <= hwdata[7:0];                            // [RULE_07]
    end
  end

  // each led pin gated and coded on its own
  genvar l;
  generate
    for (l = 0; l < pold_pkg::PORT_WIDTH; l++) begin : g_led
      assign ledSinkOn[l] =
        ledSinkEnable[l] && ledFuncSelect[l];                // [RULE_06] [RULE_09]
      assign ledCurrentCode[l] =
        {ledLevelMsb[l], ledLevelLsb[l]};                    // [RULE_08] [RULE_09]
    end
  endgenerate

  // read selection; a write still in its data phase is forwarded
  assign storedByte = portReadOr[pold_pkg::NUM_PORTS-1] |
                      ({8{sinkReadHit}} & ledSinkEnable) |
                      ({8{msbReadHit}} & ledLevelMsb) |
                      ({8{lsbReadHit}} & ledLevelLsb);
  assign writeBypass = dataWrite &&
    (dataPhase.index == addrPhase.index) &&
    (|{portReadHit, sinkReadHit, msbReadHit, lsbReadHit});
  assign readByte    = writeBypass ? hwdata[7:0] : storedByte;   // [RULE_10]
  assign next_hrdata = {24'h000000, readByte};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase.valid && !addrPhase.write) begin
      hrdata <= next_hrdata;                                 // [RULE_10]
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  logic [4:0][7:0] chkAllowed;
  logic [4:0][7:0] chkOpenDrain;
  generate
    for (p = 0; p < pold_pkg::NUM_PORTS; p++) begin : g_chk
      assign chkAllowed[p]   = pinCfg[p].isOutput & ~pinCfg[p].altFunc;
      assign chkOpenDrain[p] = pinCfg[p].openDrain;
    end
  endgenerate

  AST_PIN_GATED: assert property ( // [RULE_01]
    ((~chkAllowed) & ~pinOutEn_n) == '0)
    else $error("pin driven while not an output or in alternate use");

  AST_PIN_LEVEL: assert property ( // [RULE_02]
    (dataWrite && dataPhase.index == pold_pkg::IDX_PORT_C_OUTPUT_VALUE)
    |=> pinOut[2] == $past(hwdata[7:0]))
    else $error("port c pin level does not follow written value");

  AST_OPEN_DRAIN: assert property ( // [RULE_03]
    (chkOpenDrain & pinOut & ~pinOutEn_n) == '0)
    else $error("open drain pin actively driven high");

  AST_PORT_RESET: assert property ( // [RULE_04]
    $rose(reset_n) |-> (pinOut == '0 && ledSinkEnable == 8'h00))
    else $error("port output value not zero after reset");

  AST_SINK_WRITE: assert property ( // [RULE_05]
    sinkWriteHit |=> ledSinkEnable == $past(hwdata[7:0]))
    else $error("sink enable register did not take written value");

  AST_SINK_GATED: assert property ( // [RULE_06]
    (ledSinkOn & ~ledFuncSelect) == 8'h00)
    else $error("current sink on without led function selected");

  AST_LEVEL_RESET: assert property ( // [RULE_07]
    $rose(reset_n) |-> ledCurrentCode == '0)
    else $error("led level registers not zero after reset");

  AST_LEVEL_CODE: assert property ( // [RULE_08]
    msbWriteHit |=> ledCurrentCode[0][1] == $past(hwdata[0]) &&
                    ledCurrentCode[0][0] == $past(ledLevelLsb[0]))
    else $error("led level code msb not from high register");

  AST_PIN_INDEPENDENT: assert property ( // [RULE_09]
    (lsbWriteHit && !msbWriteHit) |=> $stable(ledLevelMsb) &&
      ledCurrentCode[5][0] == $past(hwdata[5]))
    else $error("led level write disturbed another setting");

  AST_READBACK: assert property ( // [RULE_10]
    (addrPhase.valid && !addrPhase.write && sinkReadHit && !dataWrite)
    |=> hrdata == {24'h000000, $past(ledSinkEnable)})
    else $error("read of sink enable returned wrong value");

  AST_BUS_OKAY: assert property (
    hreadyout && hresp == pold_pkg::HRESP_OKAY)
    else $error("slave inserted wait or error response");

  AST_PIN_DRIVE_LOW: assert property ( // [RULE_02]
    (chkAllowed & ~portOutputValue & pinOutEn_n) == '0)
    else $error("allowed pin holding zero not driven low");

  AST_PIN_DRIVE_HIGH: assert property ( // [RULE_02]
    (chkAllowed & portOutputValue & ~chkOpenDrain & pinOutEn_n) == '0)
    else $error("push pull pin holding one not driven");

  AST_PORT_A_WRITE: assert property ( // [RULE_04]
    (dataWrite && dataPhase.index == pold_pkg::IDX_PORT_A_OUTPUT_VALUE)
    |=> pinOut[0] == $past(hwdata[7:0]))
    else $error("port a did not take written value");

  AST_PORT_E_WRITE: assert property ( // [RULE_04]
    portWriteHit[4] |=> portOutputValue[4] == $past(hwdata[7:0]))
    else $error("port e did not take written value");

  AST_REG_HOLD: assert property ( // [RULE_04] [RULE_05] [RULE_07]
    !dataWrite |=> $stable(portOutputValue) && $stable(ledSinkEnable) &&
                   $stable(ledLevelMsb) && $stable(ledLevelLsb))
    else $error("register changed without a write");

  AST_SINK_CONNECT: assert property ( // [RULE_05]
    (ledSinkEnable & ledFuncSelect & ~ledSinkOn) == 8'h00)
    else $error("enabled led pin sink not connected");

  AST_LEVEL_LSB: assert property ( // [RULE_08]
    lsbWriteHit |=> ledCurrentCode[7][0] == $past(hwdata[7]) &&
                    ledCurrentCode[7][1] == $past(ledLevelMsb[7]))
    else $error("led level code lsb not from low register");

  AST_MSB_ALONE: assert property ( // [RULE_09]
    msbWriteHit |=> $stable(ledLevelLsb) && $stable(ledSinkEnable))
    else $error("led high level write disturbed another setting");

  AST_READ_PORT: assert property ( // [RULE_10]
    (addrPhase.valid && !addrPhase.write && portReadHit[1] && !dataWrite)
    |=> hrdata == {24'h000000, $past(portOutputValue[1])})
    else $error("read of port b returned wrong value");

  AST_READ_UNMAPPED: assert property ( // [RULE_10]
    (addrPhase.valid && !addrPhase.write &&
     !(|{portReadHit, sinkReadHit, msbReadHit, lsbReadHit}))
    |=> hrdata == 32'h00000000)
    else $error("read of unmapped index not zero");

  AST_READ_UPPER: assert property ( // [RULE_10]
    hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  AST_READ_RESET: assert property ( // [RULE_10]
    $rose(reset_n) |-> hrdata == 32'h00000000)
    else $error("read data not zero after reset");

  COV_PORT_WRITE: cover property (portWriteHit[0] ##1 !pinOutEn_n[0][0]);
  COV_SINK_ON:    cover property (ledSinkOn != 8'h00);
  COV_CODE_20MA:  cover property (
    ledCurrentCode[3] == pold_pkg::LED_20MA);
  COV_READ_PORT:  cover property (
    addrPhase.valid && !addrPhase.write && portReadHit[4]);
  COV_OD_RELEASE: cover property (
    (chkAllowed & chkOpenDrain & portOutputValue) != '0);

endmodule

// >>> pold_pad_model.sv
// pads with board pull-ups and led loads at the port pins
`timescale 1ns/100ps
module pold_pad_model (
  input  wire logic [4:0][7:0] pinOut,
  input  wire logic [4:0][7:0] pinOutEn_n,
  input  wire logic [7:0]      ledSinkOn,
  input  wire logic [7:0][1:0] ledCurrentCode,
  output logic [4:0][7:0]      padLevel,
  output logic [7:0][4:0]      sinkMa
);
  // a released pin is pulled high by the board
  assign padLevel = pinOut | pinOutEn_n;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (ledCurrentCode[i])
        2'h0: sinkMa[i] = 5'h03;
        2'h1: sinkMa[i] = 5'h07;
        2'h2: sinkMa[i] = 5'h0d;
        default: sinkMa[i] = 5'h14;
      endcase
      if (!ledSinkOn[i]) begin
        sinkMa[i] = 5'h00;
      end
    end
  end
endmodule

// >>> testbench.sv
// self-checking bench for the port output and led drive block
`timescale 1ns/100ps
module testbench;
  logic                             core_clk = 1'b0;
  logic                             reset_n  = 1'b0;
  logic                             hsel     = 1'b0;
  logic                             hwrite   = 1'b0;
  logic                             dataRd   = 1'b0;
  logic                             hready;
  logic                             hreadyout;
  logic [1:0]                       htrans   = 2'h0;
  logic [1:0]                       hresp;
  logic [31:0]                      haddr    = 32'h0;
  logic [31:0]                      hwdata   = 32'h0;
  logic [31:0]                      hrdata;
  pold_pkg::pold_pin_cfg_type [4:0] pinCfg   = '0;
  logic [7:0]                       ledFuncSelect = 8'h00;
  logic [4:0][7:0]                  pinOut, pinOutEn_n, padLevel;
  logic [7:0]                       ledSinkOn;
  logic [7:0][1:0]                  ledCurrentCode;
  logic [7:0][4:0]                  sinkMa;
  logic [11:0]                      idxTab [8];
  logic [7:0]                       shadow [8];
  logic [31:0]                      expQ [$];
  int                               n_errors = 0;
  int                               compares = 0;
  int                               cycles   = 0;
  localparam logic [4:0] MA [4] = '{5'h03, 5'h07, 5'h0d, 5'h14};

  assign hready = hreadyout;
  always #25 core_clk = ~core_clk;

  pold_top DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pinCfg(pinCfg), .ledFuncSelect(ledFuncSelect),
    .pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .ledSinkOn(ledSinkOn),
    .ledCurrentCode(ledCurrentCode));
  pold_pad_model pads (.pinOut(pinOut), .pinOutEn_n(pinOutEn_n),
    .ledSinkOn(ledSinkOn), .ledCurrentCode(ledCurrentCode),
    .padLevel(padLevel), .sinkMa(sinkMa));

  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    dataRd <= ~wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    dataRd <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] v);
    expQ.push_back({24'h0, v});
    bus(1'b0, idx, $urandom);
  endtask

  task automatic wr(input int k, input logic [31:0] wd);
    bus(1'b1, idxTab[k], wd);
    shadow[k] = wd[7:0];
  endtask

  task automatic pins_and_leds();
    logic [7:0] drv;
    logic [7:0] want;
    @(negedge core_clk);
    for (int p = 0; p < 5; p++) begin
      drv = pinCfg[p].isOutput & ~pinCfg[p].altFunc
          & (~shadow[3+p] | ~pinCfg[p].openDrain);
      want = shadow[3+p] | ~drv;
      check(32'(padLevel[p]), 32'(want));
      want = ~drv;
      check(32'(pinOutEn_n[p]), 32'(want));
      check(32'(pinOut[p]), 32'(shadow[3+p]));
    end
    check(32'(ledSinkOn), 32'(shadow[0] & ledFuncSelect));
    for (int i = 0; i < 8; i++) begin
      want = 8'({shadow[1][i], shadow[2][i]});
      check(32'(ledCurrentCode[i]), 32'(want));
      check(32'(sinkMa[i]), (shadow[0][i] & ledFuncSelect[i])
        ? 32'(MA[{shadow[1][i], shadow[2][i]}]) : 32'h0);
    end
    @(posedge core_clk);
  endtask

  // read data is compared when its data phase closes
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      close_out();
    end else if (dataRd && expQ.size() > 0) begin
      check(hrdata, expQ.pop_front());
      check(32'(hresp), 32'(pold_pkg::HRESP_OKAY));
    end
  end

  initial begin
    void'($urandom(32'hd717));
    idxTab = '{pold_pkg::IDX_LED_SINK_ENABLE, pold_pkg::IDX_LED_LEVEL_MSB,
      pold_pkg::IDX_LED_LEVEL_LSB, pold_pkg::IDX_PORT_A_OUTPUT_VALUE,
      pold_pkg::IDX_PORT_B_OUTPUT_VALUE, pold_pkg::IDX_PORT_C_OUTPUT_VALUE,
      pold_pkg::IDX_PORT_D_OUTPUT_VALUE, pold_pkg::IDX_PORT_E_OUTPUT_VALUE};
    for (int r = 0; r < 2; r++) begin
      reset_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (shadow[k]) shadow[k] = 8'h00;
      @(posedge core_clk);
      foreach (idxTab[k]) rd(idxTab[k], 8'h00);
      pins_and_leds();
      bus(1'b1, 12'h000, 32'hff);
      rd(12'h000, 8'h00);
      for (int c = 0; c < 4; c++) begin
        ledFuncSelect <= 8'hff;
        wr(0, 32'hff);
        wr(1, {24'h0, {8{c[1]}}});
        wr(2, {24'h0, {8{c[0]}}});
        pins_and_leds();
      end
      for (int n = 0; n < 60; n++) begin
        automatic int k = $urandom_range(7);
        wr(k, $urandom);
        rd(idxTab[k], shadow[k]);
        pinCfg <= 120'({$urandom, $urandom, $urandom, $urandom});
        ledFuncSelect <= 8'($urandom);
        @(posedge core_clk);
        pins_and_leds();
      end
    end
    repeat (2) @(posedge core_clk);
    close_out();
  end
endmodule
